/* hw/irc_ctrl.sv */
// Interrupt request controller: request flags, global enable, stack sequencer, Wishbone slave
//
// Decided for this implementation: register access over Wishbone and the register offsets.
module irc_ctrl (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Wishbone slave
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [irc_pkg::ADR_W-1:0]         wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [irc_pkg::WB_W-1:0]          wb_dat_i,
    output logic      [irc_pkg::WB_W-1:0]          wb_dat_o,
    output logic                                   wb_ack_o,
    // Request sources
    input  wire logic [1:0]                        pin_choice_option_a_i,
    input  wire logic [1:0]                        pin_choice_option_b_i,
    input  wire logic                              pin_choice_sel_i,
    input  wire logic                              wide_timer_source_i,
    input  wire logic                              comparator_source_i,
    input  wire logic                              led_pwm_source_i,
    input  wire logic                              narrow_timer_source_i,
    // CPU core
    input  wire logic                              insn_boundary_i,
    input  wire logic                              engint_i,
    input  wire logic                              disgint_i,
    input  wire logic                              reti_i,
    input  wire logic                              pushaf_i,
    input  wire logic                              popaf_i,
    input  wire logic [irc_pkg::PC_W-1:0]          pc_i,
    input  wire logic [irc_pkg::BYTE_W-1:0]        working_register_i,
    input  wire logic [irc_pkg::BYTE_W-1:0]        flags_i,
    output logic                                   busy_o,
    output logic                                   global_enable_o,
    output logic                                   pc_load_o,
    output logic      [irc_pkg::PC_W-1:0]          pc_load_value_o,
    output logic                                   working_register_load_o,
    output logic      [irc_pkg::BYTE_W-1:0]        working_register_value_o,
    output logic                                   flags_load_o,
    output logic      [irc_pkg::BYTE_W-1:0]        flags_value_o,
    // Data memory
    output logic      [irc_pkg::SP_W-1:0]          dmem_addr_o,
    output logic      [irc_pkg::BYTE_W-1:0]        dmem_wdata_o,
    output logic                                   dmem_we_o,
    output logic                                   dmem_re_o,
    input  wire logic [irc_pkg::BYTE_W-1:0]        dmem_rdata_i,
    // Interrupt
    output logic                                   irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [irc_pkg::NUM_SRC-1:0] src_vec;
    logic [irc_pkg::NUM_SRC-1:0] req_flags;
    logic [irc_pkg::NUM_SRC-1:0] req_clr;
    logic [irc_pkg::NUM_SRC-1:0] source_enable_bits_r;
    logic [irc_pkg::EDGE_W-1:0]  edge_sel_r;
    logic [irc_pkg::NUM_EV-1:0]  int_stat_r;
    logic [irc_pkg::NUM_EV-1:0]  int_mask_r;
    logic [irc_pkg::NUM_EV-1:0]  int_ev;
    logic [irc_pkg::NUM_EV-1:0]  int_clr;
    logic [irc_pkg::SP_W-1:0]    stack_pointer;
    logic [irc_pkg::PC_W-1:0]    save_word_r;
    logic [irc_pkg::BYTE_W-1:0]  rd_lo_r;
    logic                        pin_sel_r;
    logic                        ge_r;
    logic                        bus_req;
    logic                        bus_wr;
    logic                        sp_wr;
    logic                        any_op;
    logic                        take_irq;
    logic                        start_push;
    logic                        ret_done;
    irc_pkg::irc_state_t         state_r;
    irc_pkg::irc_op_t            op_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Request lines

    // Programming option: caught while reset is held, constant afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sel_r <= pin_choice_sel_i;
        end
    end

    always_comb begin
        src_vec                              = '0;
        src_vec[irc_pkg::SRC_EXT0]           = pin_sel_r ? pin_choice_option_b_i[0]
                                                         : pin_choice_option_a_i[0];
        src_vec[irc_pkg::SRC_EXT1]           = pin_sel_r ? pin_choice_option_b_i[1]
                                                         : pin_choice_option_a_i[1];
        src_vec[irc_pkg::SRC_WIDE_TMR]       = wide_timer_source_i;
        src_vec[irc_pkg::SRC_COMPARATOR]     = comparator_source_i;
        src_vec[irc_pkg::SRC_LED_PWM]        = led_pwm_source_i;
        src_vec[irc_pkg::SRC_NARROW_TMR]     = narrow_timer_source_i;
    end

    for (genvar g = 0; g < irc_pkg::NUM_SRC; g++) begin : g_cell
        irc_flag_cell u_cell (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .src_i      (src_vec[g]),
            .edge_sel_i (edge_sel_r[2*g +: 2]),
            .clr_i      (req_clr[g]),
            .flag_o     (req_flags[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone decode
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    assign sp_wr   = bus_wr & wb_sel_i[0] & (wb_adr_i == irc_pkg::REG_STACK);

    // A zero written to a request bit clears it; ones leave flags alone
    assign req_clr = (bus_wr & wb_sel_i[0] & (wb_adr_i == irc_pkg::REG_REQUEST))
                   ? ~wb_dat_i[irc_pkg::NUM_SRC-1:0] : '0;
    assign int_clr = (bus_wr & wb_sel_i[0] & (wb_adr_i == irc_pkg::REG_INT_STAT))
                   ? wb_dat_i[irc_pkg::NUM_EV-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_enable_bits_r <= irc_pkg::RST_ENABLE;
            edge_sel_r           <= irc_pkg::RST_EDGE;
            int_mask_r           <= irc_pkg::RST_MASK;
        end else if (bus_wr) begin
            if (wb_sel_i[0] && wb_adr_i == irc_pkg::REG_ENABLE) begin
                source_enable_bits_r <= wb_dat_i[irc_pkg::NUM_SRC-1:0];
            end
            if (wb_sel_i[0] && wb_adr_i == irc_pkg::REG_EDGE) begin
                edge_sel_r[irc_pkg::BYTE_W-1:0] <= wb_dat_i[irc_pkg::BYTE_W-1:0];
            end
            if (wb_sel_i[1] && wb_adr_i == irc_pkg::REG_EDGE) begin
                edge_sel_r[irc_pkg::EDGE_W-1:irc_pkg::BYTE_W] <=
                    wb_dat_i[irc_pkg::EDGE_W-1:irc_pkg::BYTE_W];
            end
            if (wb_sel_i[0] && wb_adr_i == irc_pkg::REG_INT_MASK) begin
                int_mask_r <= wb_dat_i[irc_pkg::NUM_EV-1:0];
            end
        end
    end

    // Unmapped offsets still answer, with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req) begin
            case (wb_adr_i)
                irc_pkg::REG_ENABLE:   wb_dat_o <= 32'(source_enable_bits_r);
                irc_pkg::REG_REQUEST:  wb_dat_o <= 32'(req_flags);
                irc_pkg::REG_EDGE:     wb_dat_o <= 32'(edge_sel_r);
                irc_pkg::REG_STACK:    wb_dat_o <= 32'(stack_pointer);
                irc_pkg::REG_STATUS:   wb_dat_o <= 32'({pin_sel_r, busy_o, ge_r});
                irc_pkg::REG_INT_STAT: wb_dat_o <= 32'(int_stat_r);
                irc_pkg::REG_INT_MASK: wb_dat_o <= 32'(int_mask_r);
                default:               wb_dat_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Entry decision and global enable

    // Instruction strobes win over entry so an operation in flight is never split
    assign any_op     = reti_i | pushaf_i | popaf_i;
    assign take_irq   = (state_r == irc_pkg::ST_IDLE) & insn_boundary_i & ~any_op & ge_r
                      & (|(req_flags & source_enable_bits_r));
    assign start_push = take_irq | ((state_r == irc_pkg::ST_IDLE) & pushaf_i & ~reti_i);
    assign ret_done   = (state_r == irc_pkg::ST_RD_END) & (op_r == irc_pkg::OP_RETI);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ge_r <= 1'b0;
        end else if (take_irq) begin
            ge_r <= 1'b0;
        end else if (ret_done) begin
            ge_r <= 1'b1;
        end else if (engint_i) begin
            ge_r <= 1'b1;
        end else if (disgint_i) begin
            ge_r <= 1'b0;
        end
    end

    assign global_enable_o = ge_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Stack pointer
    irc_stack_ptr u_sp (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (sp_wr),
        .wdata_i (wb_dat_i[irc_pkg::SP_W-1:0]),
        .inc_i   (state_r == irc_pkg::ST_WR_END),
        .dec_i   (state_r == irc_pkg::ST_RD_END),
        .sp_o    (stack_pointer)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Stack sequencer: two byte cycles to data memory, low byte at the lower address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r      <= irc_pkg::ST_IDLE;
            op_r         <= irc_pkg::OP_ENTRY;
            save_word_r  <= '0;
            busy_o       <= 1'b0;
            dmem_addr_o  <= '0;
            dmem_wdata_o <= '0;
            dmem_we_o    <= 1'b0;
            dmem_re_o    <= 1'b0;
        end else begin
            case (state_r)
                irc_pkg::ST_IDLE: begin
                    if (reti_i || popaf_i) begin
                        op_r        <= reti_i ? irc_pkg::OP_RETI : irc_pkg::OP_POPAF;
                        busy_o      <= 1'b1;
                        dmem_re_o   <= 1'b1;
                        dmem_addr_o <= stack_pointer - irc_pkg::SP_STEP;
                        state_r     <= irc_pkg::ST_RD_HI;
                    end else if (start_push) begin
                        op_r         <= take_irq ? irc_pkg::OP_ENTRY : irc_pkg::OP_PUSHAF;
                        save_word_r  <= take_irq ? pc_i
                                                 : {flags_i, working_register_i};
                        busy_o       <= 1'b1;
                        dmem_we_o    <= 1'b1;
                        dmem_addr_o  <= stack_pointer;
                        dmem_wdata_o <= take_irq ? pc_i[irc_pkg::BYTE_W-1:0]
                                                 : working_register_i;
                        state_r      <= irc_pkg::ST_WR_HI;
                    end
                end
                irc_pkg::ST_WR_HI: begin
                    dmem_addr_o  <= stack_pointer + irc_pkg::SP_ONE;
                    dmem_wdata_o <= save_word_r[irc_pkg::PC_W-1:irc_pkg::BYTE_W];
                    state_r      <= irc_pkg::ST_WR_END;
                end
                irc_pkg::ST_WR_END: begin
                    dmem_we_o <= 1'b0;
                    busy_o    <= 1'b0;
                    state_r   <= irc_pkg::ST_IDLE;
                end
                irc_pkg::ST_RD_HI: begin
                    dmem_addr_o <= stack_pointer - irc_pkg::SP_ONE;
                    state_r     <= irc_pkg::ST_RD_CAP;
                end
                irc_pkg::ST_RD_CAP: begin
                    dmem_re_o <= 1'b0;
                    state_r   <= irc_pkg::ST_RD_END;
                end
                irc_pkg::ST_RD_END: begin
                    busy_o  <= 1'b0;
                    state_r <= irc_pkg::ST_IDLE;
                end
                default: begin
                    busy_o    <= 1'b0;
                    dmem_we_o <= 1'b0;
                    dmem_re_o <= 1'b0;
                    state_r   <= irc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Memory answers one cycle after the read strobe, so the low byte lands here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_lo_r <= '0;
        end else if (state_r == irc_pkg::ST_RD_CAP) begin
            rd_lo_r <= dmem_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Results to the core, one-cycle pulses with held values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_load_o                <= 1'b0;
            pc_load_value_o          <= '0;
            working_register_load_o  <= 1'b0;
            working_register_value_o <= '0;
            flags_load_o             <= 1'b0;
            flags_value_o            <= '0;
        end else begin
            pc_load_o               <= 1'b0;
            working_register_load_o <= 1'b0;
            flags_load_o            <= 1'b0;
            if (state_r == irc_pkg::ST_WR_END && op_r == irc_pkg::OP_ENTRY) begin
                pc_load_o       <= 1'b1;
                pc_load_value_o <= irc_pkg::VECTOR_ADDR;
            end
            if (ret_done) begin
                pc_load_o       <= 1'b1;
                pc_load_value_o <= {dmem_rdata_i, rd_lo_r};
            end
            if (state_r == irc_pkg::ST_RD_END && op_r == irc_pkg::OP_POPAF) begin
                working_register_load_o  <= 1'b1;
                working_register_value_o <= rd_lo_r;
                flags_load_o             <= 1'b1;
                flags_value_o            <= dmem_rdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky event status, write one to clear, set wins over clear

    // An odd stack pointer at a push means software broke the alignment it must keep
    always_comb begin
        int_ev                     = '0;
        int_ev[irc_pkg::EV_ENTRY]  = take_irq;
        int_ev[irc_pkg::EV_RETURN] = ret_done;
        int_ev[irc_pkg::EV_SP_ODD] = start_push & stack_pointer[0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_stat_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat_r & int_mask_r);
        end
    end

endmodule

/* hw/irc_pkg.sv */
// Shared constants, register map and state encodings of the interrupt request controller
package irc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int NUM_SRC = 6;
    localparam int EDGE_W  = 2 * NUM_SRC;
    localparam int NUM_EV  = 3;
    localparam int PC_W    = 16;
    localparam int SP_W    = 8;
    localparam int BYTE_W  = 8;
    localparam int ADR_W   = 8;
    localparam int WB_W    = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Request line positions
    localparam int SRC_EXT0       = 0;
    localparam int SRC_EXT1       = 1;
    localparam int SRC_WIDE_TMR   = 2;
    localparam int SRC_COMPARATOR = 3;
    localparam int SRC_LED_PWM    = 4;
    localparam int SRC_NARROW_TMR = 5;

    // Edge select codes, two bits per request line
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADR_W-1:0] REG_ENABLE   = 8'h00;
    localparam logic [ADR_W-1:0] REG_REQUEST  = 8'h04;
    localparam logic [ADR_W-1:0] REG_EDGE     = 8'h08;
    localparam logic [ADR_W-1:0] REG_STACK    = 8'h0C;
    localparam logic [ADR_W-1:0] REG_STATUS   = 8'h10;
    localparam logic [ADR_W-1:0] REG_INT_STAT = 8'h14;
    localparam logic [ADR_W-1:0] REG_INT_MASK = 8'h18;

    // Status register fields
    localparam int STAT_GIE     = 0;
    localparam int STAT_BUSY    = 1;
    localparam int STAT_PIN_SEL = 2;

    // Event bits of the sticky interrupt status
    localparam int EV_ENTRY  = 0;
    localparam int EV_RETURN = 1;
    localparam int EV_SP_ODD = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed numbers
    localparam logic [NUM_SRC-1:0] RST_ENABLE = 6'h00;
    localparam logic [EDGE_W-1:0]  RST_EDGE   = 12'h000;
    localparam logic [SP_W-1:0]    RST_SP     = 8'h00;
    localparam logic [NUM_EV-1:0]  RST_MASK   = 3'h0;
    localparam logic [PC_W-1:0]    VECTOR_ADDR = 16'h0010;
    localparam logic [SP_W-1:0]    SP_STEP    = 8'h02;
    localparam logic [SP_W-1:0]    SP_ONE     = 8'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // Stack sequencer states and operations
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_WR_HI  = 6'h02,
        ST_WR_END = 6'h04,
        ST_RD_HI  = 6'h08,
        ST_RD_CAP = 6'h10,
        ST_RD_END = 6'h20
    } irc_state_t;

    typedef enum logic [3:0] {
        OP_ENTRY  = 4'h1,
        OP_PUSHAF = 4'h2,
        OP_RETI   = 4'h4,
        OP_POPAF  = 4'h8
    } irc_op_t;

endpackage

/* hw/irc_flag_cell.sv */
// One request line: edge detector and sticky request flag
module irc_flag_cell (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Source and control
    input  wire logic       src_i,
    input  wire logic [1:0] edge_sel_i,
    input  wire logic       clr_i,
    // Flag
    output logic            flag_o
);

    logic prev_r;
    logic rise;
    logic fall;
    logic hit;

    // Seeded with the live level so a high source does not fake an edge at release
    always_ff @(posedge clk_i) begin
        prev_r <= src_i;
    end

    assign rise = src_i & ~prev_r;
    assign fall = ~src_i & prev_r;

    always_comb begin
        case (edge_sel_i)
            irc_pkg::EDGE_RISE: hit = rise;
            irc_pkg::EDGE_FALL: hit = fall;
            irc_pkg::EDGE_BOTH: hit = rise | fall;
            default:            hit = rise | fall;
        endcase
    end

    // Set regardless of the line enable; a set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= (flag_o & ~clr_i) | hit;
        end
    end

endmodule

/* hw/irc_stack_ptr.sv */
// Stack pointer register: software load, hardware step up or down by two
module irc_stack_ptr (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Software load
    input  wire logic                      wr_i,
    input  wire logic [irc_pkg::SP_W-1:0]  wdata_i,
    // Hardware steps
    input  wire logic                      inc_i,
    input  wire logic                      dec_i,
    // Value
    output logic      [irc_pkg::SP_W-1:0]  sp_o
);

    // Hardware steps win over a software load landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_o <= irc_pkg::RST_SP;
        end else if (inc_i) begin
            sp_o <= sp_o + irc_pkg::SP_STEP;
        end else if (dec_i) begin
            sp_o <= sp_o - irc_pkg::SP_STEP;
        end else if (wr_i) begin
            sp_o <= wdata_i;
        end
    end

endmodule

/* tb/irc_ctrl_checker.sv */
// Port assertions for the interrupt request controller
module irc_ctrl_checker (
    // Clock, reset and bus
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
    // Core side
    input wire logic        insn_boundary_i, engint_i, disgint_i, reti_i, pushaf_i, popaf_i,
    input wire logic        busy_o, global_enable_o, pc_load_o, working_register_load_o,
    input wire logic        flags_load_o,
    input wire logic [15:0] pc_load_value_o,
    // Data memory
    input wire logic        dmem_we_o, dmem_re_o,
    input wire logic [7:0]  dmem_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");
    // Busy rises one cycle after the decision; the vector load follows two cycles later
    AST_ENTRY: assert property ($rose(busy_o) && dmem_we_o && !$past(pushaf_i) |->
        !global_enable_o ##2 pc_load_o && pc_load_value_o == irc_pkg::VECTOR_ADDR)
        else $error("entry not vectored");
    AST_PUSH: assert property ($rose(busy_o) && dmem_we_o |=>
        dmem_we_o && dmem_addr_o == $past(dmem_addr_o) + 8'h01 ##1 !dmem_we_o)
        else $error("stack write pair wrong");
    AST_RET: assert property (reti_i && !busy_o |=>
        busy_o[*3] ##1 !busy_o && pc_load_o && global_enable_o)
        else $error("return sequence wrong");
    AST_RADDR: assert property (reti_i && !busy_o |=>
        dmem_re_o ##1 dmem_re_o && dmem_addr_o == $past(dmem_addr_o) + 8'h01)
        else $error("stack read pair wrong");
    AST_POP: assert property (popaf_i && !busy_o |=>
        ##3 working_register_load_o && flags_load_o && !pc_load_o)
        else $error("restore loads wrong");
    AST_GON: assert property (
        engint_i && !disgint_i && !insn_boundary_i |=> global_enable_o)
        else $error("global enable not set");
    AST_GOFF: assert property (
        disgint_i && !engint_i && !busy_o |=> !global_enable_o)
        else $error("global enable not cleared");
endmodule

/* tb/irc_dmem_model.sv */
// Synchronous byte memory standing for the core's data store
module irc_dmem_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] addr_i, wdata_i,
    input  wire logic       we_i, re_i,
    output logic      [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] q = 8'h5A;
    assign rdata_o = q;
    // Off a read the data churns, so stale bytes cannot pass for a fetch
    always @(posedge clk_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
        q <= re_i ? mem[addr_i] : ~q;
    end
endmodule

/* tb/irc_ctrl_bench.sv */
// Self-checking bench: registers, edges, entry, save, restore and return
module irc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = '0, rst_i = 1'b1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o;
    logic [7:0] wb_adr_i = '0, working_register_i = 8'h5A, flags_i = 8'h3C, dmem_rdata_i;
    logic [7:0] dmem_addr_o, dmem_wdata_o, working_register_value_o, flags_value_o;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic [1:0] pin_choice_option_a_i = '0, pin_choice_option_b_i = '0;
    logic pin_choice_sel_i = '0, wide_timer_source_i = '0, comparator_source_i = '0;
    logic led_pwm_source_i = '0, narrow_timer_source_i = '0, insn_boundary_i = '0;
    logic engint_i = '0, disgint_i = '0, reti_i = '0, pushaf_i = '0, popaf_i = '0;
    logic [15:0] pc_i = 16'hA5C3, pc_load_value_o;
    logic busy_o, global_enable_o, pc_load_o, working_register_load_o, flags_load_o;
    logic dmem_we_o, dmem_re_o, irq_o;
    int n_fail = 0, compares = 0;
    irc_ctrl u_irc_ctrl (.*);
    irc_dmem_model u_irc_dmem_model (.clk_i, .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o),
        .we_i(dmem_we_o), .re_i(dmem_re_o), .rdata_o(dmem_rdata_i));
    always #2.5 clk_i = ~clk_i;
    task automatic conclude;
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Busy up then down; the load pulse stands in the cycle busy falls
    task automatic wseq;
        int n = 0;
        do begin @(posedge clk_i); n++; end while (busy_o !== 1'b1 && n < 40);
        do begin @(posedge clk_i); n++; end while (busy_o !== 1'b0 && n < 40);
        if (n >= 40) chk(32'h0, 32'h1);
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(irc_pkg::REG_STACK, 32'h0);
        rd(8'h1C, 32'h0);
        wb(1'b1, irc_pkg::REG_EDGE, 32'h090);
        {wide_timer_source_i, comparator_source_i, pin_choice_option_a_i} <= 4'hD;
        rd(irc_pkg::REG_REQUEST, 32'h09);
        wide_timer_source_i <= 1'b0;
        rd(irc_pkg::REG_REQUEST, 32'h0D);
        wb(1'b1, irc_pkg::REG_REQUEST, 32'h37);
        rd(irc_pkg::REG_REQUEST, 32'h05);
        wb(1'b1, irc_pkg::REG_REQUEST, 32'h0);
        wb(1'b1, irc_pkg::REG_STACK, 32'h20);
        wb(1'b1, irc_pkg::REG_INT_MASK, 32'h1);
        wb(1'b1, irc_pkg::REG_ENABLE, 32'h1);
        engint_i <= 1'b1;
        @(posedge clk_i);
        {engint_i, insn_boundary_i, pin_choice_option_a_i} <= 4'h4;
        rd(irc_pkg::REG_STATUS, 32'h1);
        pin_choice_option_a_i <= 2'h1;
        wseq();
        chk(pc_load_o, 1'b1);
        chk(u_irc_dmem_model.mem[8'h20], 8'hC3);
        chk(u_irc_dmem_model.mem[8'h21], 8'hA5);
        rd(irc_pkg::REG_STACK, 32'h22);
        wb(1'b1, irc_pkg::REG_REQUEST, 32'h3E);
        pushaf_i <= 1'b1;
        @(posedge clk_i);
        pushaf_i <= 1'b0;
        wseq();
        chk(u_irc_dmem_model.mem[8'h23], 8'h3C);
        popaf_i <= 1'b1;
        @(posedge clk_i);
        popaf_i <= 1'b0;
        wseq();
        chk({working_register_value_o, flags_value_o}, 16'h5A3C);
        reti_i <= 1'b1;
        @(posedge clk_i);
        reti_i <= 1'b0;
        wseq();
        chk({global_enable_o, pc_load_value_o}, 17'h1A5C3);
        rd(irc_pkg::REG_STACK, 32'h20);
        narrow_timer_source_i <= 1'b1;
        rd(irc_pkg::REG_REQUEST, 32'h20);
        chk(busy_o, 1'b0);
        disgint_i <= 1'b1;
        @(posedge clk_i);
        disgint_i <= 1'b0;
        wb(1'b1, irc_pkg::REG_ENABLE, 32'h21);
        rd(irc_pkg::REG_INT_STAT, 32'h3);
        chk({busy_o, irq_o}, 2'h1);
        wb(1'b1, irc_pkg::REG_INT_STAT, 32'h7);
        rd(irc_pkg::REG_INT_STAT, 32'h0);
        chk(irq_o, 1'b0);
        // Second reset picks the other pin option; held levels must not fake edges
        pin_choice_sel_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(irc_pkg::REG_STATUS, 32'h4);
        pin_choice_option_b_i <= 2'h2;
        rd(irc_pkg::REG_REQUEST, 32'h02);
        conclude();
    end
endmodule
bind irc_ctrl irc_ctrl_checker u_irc_ctrl_checker (.*);
